// ==== pkg/a2c1_pkg.sv ====
// Constants for the amplifier-2 switch and comparator-1 control block.
// Assumes a 32-bit APB master on pclk and 8-bit registers in low bits.
// How it works
// [R01] Amplifier 2 disabled: all three shared pins return to I/O.
// [R02] Enabled, no gain, no input switches: inputs I/O, third pin output.
// [R03] Positive switch claims non-inverting pin; negative claims inverting.
// [R04] Gain enable claims inverting pin; with negative switch, bypass resistor.
// [R05] Calibration mode closes only the two input-pin switches.
// [R06] Normal mode, both inputs, no gain or feedback: only the two input-pin switches close.
// [R07] Positive switch clear: source 01 high, 10 mid, 11 low, 00 none.
// [R08] Feedback with positive switch: buffer, inverting-pin switch open.
// [R09] Feedback, no input switches: only selected reference switch closes.
// [R10] Bit 7 of comparator register 0 is live result, read only.
// [R11] Bit 6 of comparator register 0 selects offset cancellation mode.
// [R12] Cancellation mode forces both comparator source selects to 1.
// [R13] Bit 5 chooses calibration reference: 0 inverting, 1 shared pin.
// [R14] Bits 4..0 hold trim, resetting to 10000; others reset 0.
// [R15] Bit 7 of register 1 selects shared source; resets to 1.
// [R16] Bits 6..4 of register 1 ignore writes and read 0.
// [R17] Bit 3 of register 1 enables the interrupt request; resets 0.
// [R18] Result transitions under edge selection make an interrupt trigger.
// [R19] Gain enable closes both gain switches; disable opens them.
// [R20] Positive switch opens cross-connect and references; negative opens inv.
// [R21] Amplifier disabled opens gain switches and feedback switch.
// [R22] Comparator inverting select: 0 internal high level, 1 pin.
// [R23] Switch and pin outputs registered; power-on values during reset.
// [R24] Comparator result passes two flip-flops before any use.
package a2c1_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] A2C1_CMP_TRIM_ADDR  = 8'h00;
  localparam logic [7:0] A2C1_CMP_ROUTE_ADDR = 8'h04;
  localparam logic [7:0] A2C1_AMP_CTRL_ADDR  = 8'h08;
  localparam logic [7:0] A2C1_AMP_ROUTE_ADDR = 8'h0C;
  localparam logic [7:0] A2C1_STATUS_ADDR    = 8'h10;
  localparam logic [7:0] A2C1_EDGE_ADDR      = 8'h14;

  // ----------------------------------------------------------------------
  // Comparator register fields
  // ----------------------------------------------------------------------
  localparam int A2C1_CMP_RESULT_BIT = 7;
  localparam int A2C1_CMP_CAL_BIT    = 6;
  localparam int A2C1_CMP_REF_BIT    = 5;
  localparam int A2C1_CMP_NSRC_BIT   = 7;
  localparam int A2C1_CMP_IRQ_BIT    = 3;
  localparam int A2C1_CMP_OUT_BIT    = 2;
  localparam int A2C1_CMP_ISRC_BIT   = 1;
  localparam int A2C1_CMP_EN_BIT     = 0;
  localparam logic [4:0] A2C1_TRIM_RST = 5'h10;

  // ----------------------------------------------------------------------
  // Amplifier control fields
  // ----------------------------------------------------------------------
  localparam int A2C1_AMP_EN_BIT   = 0;
  localparam int A2C1_AMP_PS_BIT   = 1;
  localparam int A2C1_AMP_NS_BIT   = 2;
  localparam int A2C1_AMP_SEL_LSB  = 3;
  localparam int A2C1_AMP_FB_BIT   = 5;
  localparam int A2C1_AMP_CAL_BIT  = 6;
  localparam int A2C1_AMP_REF_BIT  = 7;
  localparam int A2C1_RT_XP_BIT    = 0;
  localparam int A2C1_RT_XN_BIT    = 1;
  localparam int A2C1_RT_PGA_BIT   = 2;
  localparam int A2C1_RT_GAIN_LSB  = 3;
  localparam logic [7:0] A2C1_AMP_CTRL_RST  = 8'h06;
  localparam logic [7:0] A2C1_AMP_ROUTE_RST = 8'h00;

  // Non-inverting source codes
  localparam logic [1:0] A2C1_SRC_NONE = 2'h0;
  localparam logic [1:0] A2C1_SRC_HIGH = 2'h1;
  localparam logic [1:0] A2C1_SRC_MID  = 2'h2;
  localparam logic [1:0] A2C1_SRC_LOW  = 2'h3;

  // Interrupt edge selection codes
  localparam logic [1:0] A2C1_EDGE_OFF  = 2'h0;
  localparam logic [1:0] A2C1_EDGE_RISE = 2'h1;
  localparam logic [1:0] A2C1_EDGE_FALL = 2'h2;
  localparam logic [1:0] A2C1_EDGE_BOTH = 2'h3;

endpackage : a2c1_pkg

// ==== hw/a2c1_ctrl.sv ====
// Amplifier-2 switch and pin control plus comparator-1 registers.
// Assumes an APB master on pclk and an asynchronous comparator result.
`timescale 1ns/1ps
module a2c1_ctrl (
  // APB clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Amplifier 2 switches
  output logic             sw_noninv_pin,
  output logic             sw_inv_pin,
  output logic             sw_gain_network,
  output logic             sw_inv_cross_connect,
  output logic             sw_output_feedback,
  output logic             sw_noninv_cross_connect,
  output logic             sw_high_reference,
  output logic             sw_mid_reference,
  output logic             sw_low_reference,
  // Amplifier 2 pins and modes
  output logic             amp2_noninv_pin,
  output logic             amp2_inv_pin,
  output logic             amp2_output_pin,
  output logic             gain_input_resistor_bypass,
  output logic             amp2_cal_active,
  output logic             amp2_cal_ref_noninv,
  output logic [2:0]       amp2_gain_select,
  // Comparator 1
  input  wire logic        comp1_result_async,
  output logic             comp1_enable,
  output logic             comp1_pin_output_enable,
  output logic             comp1_noninv_from_pin,
  output logic             comp1_inv_from_pin,
  output logic             comp1_offset_cal_mode,
  output logic             comp1_cal_ref_select,
  output logic [4:0]       comp1_offset_trim,
  output logic             comp1_irq_trigger
);

  // ----------------------------------------------------------------------
  // Stored control state
  // ----------------------------------------------------------------------
  logic [6:0] cmp_trim_reg;
  logic [3:0] cmp_route_reg;
  logic [7:0] amp_ctrl_reg;
  logic [5:0] amp_route_reg;
  logic [1:0] edge_sel_reg;
  logic       res_meta_reg;
  logic       res_sync_reg;
  logic       res_last_reg;
  logic [7:0] rd_byte;
  logic       addr_hit;
  logic       wr_en;

  // Switch decode results
  logic s_np;
  logic s_ip;
  logic s_gn;
  logic s_ix;
  logic s_fb;
  logic s_nx;
  logic s_hi;
  logic s_md;
  logic s_lo;
  logic rise;
  logic fall;
  logic edge_hit;

  // Field views
  logic       a_en;
  logic       a_ps;
  logic       a_ns;
  logic [1:0] a_sel;
  logic       a_fb;
  logic       a_cal;
  logic       a_xp;
  logic       a_xn;
  logic       a_pga;
  logic       c_cal;

  function automatic logic is_addr(input logic [7:0] a);
    is_addr = (a == a2c1_pkg::A2C1_CMP_TRIM_ADDR)  ||
              (a == a2c1_pkg::A2C1_CMP_ROUTE_ADDR) ||
              (a == a2c1_pkg::A2C1_AMP_CTRL_ADDR)  ||
              (a == a2c1_pkg::A2C1_AMP_ROUTE_ADDR) ||
              (a == a2c1_pkg::A2C1_STATUS_ADDR)    ||
              (a == a2c1_pkg::A2C1_EDGE_ADDR);
  endfunction : is_addr

  assign a_en  = amp_ctrl_reg[a2c1_pkg::A2C1_AMP_EN_BIT];
  assign a_ps  = amp_ctrl_reg[a2c1_pkg::A2C1_AMP_PS_BIT];
  assign a_ns  = amp_ctrl_reg[a2c1_pkg::A2C1_AMP_NS_BIT];
  assign a_sel = amp_ctrl_reg[a2c1_pkg::A2C1_AMP_SEL_LSB +: 2];
  assign a_fb  = amp_ctrl_reg[a2c1_pkg::A2C1_AMP_FB_BIT];
  assign a_cal = amp_ctrl_reg[a2c1_pkg::A2C1_AMP_CAL_BIT];
  assign a_xp  = amp_route_reg[a2c1_pkg::A2C1_RT_XP_BIT];
  assign a_xn  = amp_route_reg[a2c1_pkg::A2C1_RT_XN_BIT];
  assign a_pga = amp_route_reg[a2c1_pkg::A2C1_RT_PGA_BIT];
  assign c_cal = cmp_trim_reg[a2c1_pkg::A2C1_CMP_CAL_BIT];

  // ----------------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------------
  // Zero wait states: read data is captured in the setup cycle.
  assign addr_hit = is_addr(paddr);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_hit;
  assign wr_en    = psel & penable & pwrite & addr_hit;

  // ----------------------------------------------------------------------
  // Comparator result synchroniser
  // ----------------------------------------------------------------------
  // [R24] two-stage sync
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_meta_reg <= 1'b0;
      res_sync_reg <= 1'b0;
      res_last_reg <= 1'b0;
    end else begin
      res_meta_reg <= comp1_result_async;
      res_sync_reg <= res_meta_reg;
      res_last_reg <= res_sync_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Comparator registers
  // ----------------------------------------------------------------------
  // [R11] [R13] [R14] mode, reference, trim
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_trim_reg <= {2'h0, a2c1_pkg::A2C1_TRIM_RST};
    end else if (wr_en && paddr == a2c1_pkg::A2C1_CMP_TRIM_ADDR) begin
      // [R10] result bit not writable
      cmp_trim_reg <= pwdata[6:0];
    end
  end

  // Stored as {nsrc, irq, out, isrc} minus the always-zero bits; en is kept in cmp_en_reg.
  // [R15] [R16] [R17] [R22] routing bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_route_reg <= 4'h0;
    end else if (wr_en && paddr == a2c1_pkg::A2C1_CMP_ROUTE_ADDR) begin
      cmp_route_reg <= {~pwdata[a2c1_pkg::A2C1_CMP_NSRC_BIT],
                        pwdata[a2c1_pkg::A2C1_CMP_IRQ_BIT],
                        pwdata[a2c1_pkg::A2C1_CMP_OUT_BIT],
                        ~pwdata[a2c1_pkg::A2C1_CMP_ISRC_BIT]};
    end
  end

  // Source selects are stored inverted so reset value 1 comes from zero.
  logic cmp_en_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_en_reg <= 1'b0;
    end else if (wr_en && paddr == a2c1_pkg::A2C1_CMP_ROUTE_ADDR) begin
      cmp_en_reg <= pwdata[a2c1_pkg::A2C1_CMP_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_sel_reg <= a2c1_pkg::A2C1_EDGE_OFF;
    end else if (wr_en && paddr == a2c1_pkg::A2C1_EDGE_ADDR) begin
      edge_sel_reg <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Amplifier registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_ctrl_reg <= a2c1_pkg::A2C1_AMP_CTRL_RST;
    end else if (wr_en && paddr == a2c1_pkg::A2C1_AMP_CTRL_ADDR) begin
      amp_ctrl_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp_route_reg <= a2c1_pkg::A2C1_AMP_ROUTE_RST[5:0];
    end else if (wr_en && paddr == a2c1_pkg::A2C1_AMP_ROUTE_ADDR) begin
      amp_route_reg <= pwdata[5:0];
    end
  end

  // ----------------------------------------------------------------------
  // Switch decode
  // ----------------------------------------------------------------------
  always_comb begin
    s_np = 1'b0;
    s_ip = 1'b0;
    s_gn = 1'b0;
    s_ix = 1'b0;
    s_fb = 1'b0;
    s_nx = 1'b0;
    s_hi = 1'b0;
    s_md = 1'b0;
    s_lo = 1'b0;
    if (!a_en) begin
      // [R21] disabled opens everything
      s_np = 1'b0;
    end else if (a_cal) begin
      // [R05] calibration closes pin switches only
      s_np = 1'b1;
      s_ip = 1'b1;
    end else begin
      // [R03] [R06] input pin switches
      s_np = a_ps;
      // [R08] buffer mode keeps the inverting-pin switch open
      s_ip = a_ns & ~(a_fb & a_ps);
      // [R19] gain switches follow enable
      s_gn = a_pga;
      // [R08] [R09] feedback stays open when buffering an internal level
      s_fb = a_fb & (a_ps | a_ns | (a_sel == a2c1_pkg::A2C1_SRC_NONE));
      // [R20] pin switches win over cross-connects
      s_ix = a_xn & ~a_ns;
      s_nx = a_xp & ~a_ps;
      // [R07] reference decode when positive clear
      if (!a_ps && !a_xp) begin
        case (a_sel)
          a2c1_pkg::A2C1_SRC_HIGH: s_hi = 1'b1;
          a2c1_pkg::A2C1_SRC_MID:  s_md = 1'b1;
          a2c1_pkg::A2C1_SRC_LOW:  s_lo = 1'b1;
          default:                 s_hi = 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered switch and pin outputs
  // ----------------------------------------------------------------------
  // [R23] one clock after the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_noninv_pin           <= 1'b0;
      sw_inv_pin              <= 1'b0;
      sw_gain_network         <= 1'b0;
      sw_inv_cross_connect    <= 1'b0;
      sw_output_feedback      <= 1'b0;
      sw_noninv_cross_connect <= 1'b0;
      sw_high_reference       <= 1'b0;
      sw_mid_reference        <= 1'b0;
      sw_low_reference        <= 1'b0;
    end else begin
      sw_noninv_pin           <= s_np;
      sw_inv_pin              <= s_ip;
      sw_gain_network         <= s_gn;
      sw_inv_cross_connect    <= s_ix;
      sw_output_feedback      <= s_fb;
      sw_noninv_cross_connect <= s_nx;
      sw_high_reference       <= s_hi;
      sw_mid_reference        <= s_md;
      sw_low_reference        <= s_lo;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp2_noninv_pin            <= 1'b0;
      amp2_inv_pin               <= 1'b0;
      amp2_output_pin            <= 1'b0;
      gain_input_resistor_bypass <= 1'b0;
      amp2_cal_active            <= 1'b0;
      amp2_cal_ref_noninv        <= 1'b0;
      amp2_gain_select           <= 3'h0;
    end else begin
      // [R01] [R02] [R03] pin ownership only when enabled
      amp2_noninv_pin            <= a_en & a_ps;
      // [R04] gain enable claims inverting pin
      amp2_inv_pin               <= a_en & (a_ns | a_pga);
      amp2_output_pin            <= a_en;
      gain_input_resistor_bypass <= a_en & a_pga & a_ns;
      amp2_cal_active            <= a_en & a_cal;
      amp2_cal_ref_noninv        <=
        amp_ctrl_reg[a2c1_pkg::A2C1_AMP_REF_BIT];
      amp2_gain_select           <=
        amp_route_reg[a2c1_pkg::A2C1_RT_GAIN_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------------
  // Comparator outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp1_enable            <= 1'b0;
      comp1_pin_output_enable <= 1'b0;
      comp1_noninv_from_pin   <= 1'b1;
      comp1_inv_from_pin      <= 1'b1;
      comp1_offset_cal_mode   <= 1'b0;
      comp1_cal_ref_select    <= 1'b0;
      comp1_offset_trim       <= a2c1_pkg::A2C1_TRIM_RST;
    end else begin
      comp1_enable            <= cmp_en_reg;
      comp1_pin_output_enable <= cmp_route_reg[1];
      // [R12] calibration forces pin inputs
      comp1_noninv_from_pin   <= ~cmp_route_reg[3] | c_cal;
      comp1_inv_from_pin      <= ~cmp_route_reg[0] | c_cal;
      comp1_offset_cal_mode   <= c_cal;
      comp1_cal_ref_select    <= cmp_trim_reg[a2c1_pkg::A2C1_CMP_REF_BIT];
      comp1_offset_trim       <= cmp_trim_reg[4:0];
    end
  end

  // ----------------------------------------------------------------------
  // Edge trigger
  // ----------------------------------------------------------------------
  assign rise = res_sync_reg & ~res_last_reg;
  assign fall = ~res_sync_reg & res_last_reg;

  always_comb begin
    case (edge_sel_reg)
      a2c1_pkg::A2C1_EDGE_RISE: edge_hit = rise;
      a2c1_pkg::A2C1_EDGE_FALL: edge_hit = fall;
      a2c1_pkg::A2C1_EDGE_BOTH: edge_hit = rise | fall;
      default:                  edge_hit = 1'b0;
    endcase
  end

  // [R17] [R18] gated edge pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp1_irq_trigger <= 1'b0;
    end else begin
      comp1_irq_trigger <= edge_hit & cmp_en_reg & cmp_route_reg[2];
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    case (paddr)
      a2c1_pkg::A2C1_CMP_TRIM_ADDR: begin
        // [R10] live result in bit 7
        rd_byte = {res_sync_reg, cmp_trim_reg};
      end
      a2c1_pkg::A2C1_CMP_ROUTE_ADDR: begin
        // [R16] bits 6..4 read zero; [R12] forced selects read 1
        rd_byte = {~cmp_route_reg[3] | c_cal, 3'h0, cmp_route_reg[2:1],
                   ~cmp_route_reg[0] | c_cal, cmp_en_reg};
      end
      a2c1_pkg::A2C1_AMP_CTRL_ADDR:  rd_byte = amp_ctrl_reg;
      a2c1_pkg::A2C1_AMP_ROUTE_ADDR: rd_byte = {2'h0, amp_route_reg};
      a2c1_pkg::A2C1_STATUS_ADDR: begin
        rd_byte = {sw_low_reference, sw_mid_reference, sw_high_reference,
                   sw_output_feedback, sw_gain_network, amp2_output_pin,
                   amp2_inv_pin, amp2_noninv_pin};
      end
      a2c1_pkg::A2C1_EDGE_ADDR: rd_byte = {6'h00, edge_sel_reg};
      default:                  rd_byte = 8'h00;
    endcase
  end

  // Captured in setup so the access phase needs no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, rd_byte};
    end
  end

endmodule : a2c1_ctrl

// ==== tb/a2c1_ctrl_sva.sv ====
// Port checks for the amplifier-2 switch and comparator-1 control block.
// Assumes one pclk domain and presetn asynchronous, active low.
`timescale 1ns/1ps
module a2c1_ctrl_sva (
  // Bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // Switches and pins
  input wire logic        sw_noninv_pin,
  input wire logic        sw_inv_pin,
  input wire logic        sw_gain_network,
  input wire logic        sw_output_feedback,
  input wire logic        sw_noninv_cross_connect,
  input wire logic        sw_high_reference,
  input wire logic        sw_mid_reference,
  input wire logic        sw_low_reference,
  input wire logic        amp2_noninv_pin,
  input wire logic        amp2_inv_pin,
  input wire logic        amp2_output_pin,
  input wire logic        amp2_cal_active,
  // Comparator
  input wire logic        comp1_enable,
  input wire logic        comp1_noninv_from_pin,
  input wire logic        comp1_inv_from_pin,
  input wire logic        comp1_offset_cal_mode,
  input wire logic        comp1_irq_trigger
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pins_need_en: assert property (
    !amp2_output_pin |-> !amp2_noninv_pin && !amp2_inv_pin)
    else $error("shared pin claimed while amplifier off");
  a_gain_claims_inv: assert property (
    sw_gain_network |-> amp2_inv_pin)
    else $error("gain network closed without inverting pin");
  a_pos_priority: assert property (
    sw_noninv_pin |-> !sw_noninv_cross_connect && !sw_high_reference
      && !sw_mid_reference && !sw_low_reference)
    else $error("source switch closed beside noninverting pin");
  a_ref_onehot: assert property (
    $onehot0({sw_high_reference, sw_mid_reference, sw_low_reference}))
    else $error("more than one reference switch closed");
  a_off_opens: assert property (
    !amp2_output_pin |-> !sw_gain_network && !sw_output_feedback)
    else $error("gain or feedback closed while amplifier off");
  a_cal_only: assert property (
    amp2_cal_active |-> sw_noninv_pin && sw_inv_pin && !sw_gain_network
      && !sw_output_feedback && !sw_noninv_cross_connect)
    else $error("calibration switch pattern wrong");
  a_comp_cal_force: assert property (
    comp1_offset_cal_mode && $past(comp1_offset_cal_mode)
      |-> comp1_noninv_from_pin && comp1_inv_from_pin)
    else $error("source selects not forced in cancellation");
  a_irq_gated: assert property (
    comp1_irq_trigger |-> comp1_enable || $past(comp1_enable))
    else $error("trigger while comparator disabled");
  a_enable_follows: assert property (
    psel && penable && pwrite && paddr == a2c1_pkg::A2C1_AMP_CTRL_ADDR
      |=> ##1 amp2_output_pin == $past(pwdata[0], 2))
    else $error("output pin not following enable write");
endmodule : a2c1_ctrl_sva

bind a2c1_ctrl a2c1_ctrl_sva a2c1_ctrl_sva_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .sw_noninv_pin(sw_noninv_pin), .sw_inv_pin(sw_inv_pin),
  .sw_gain_network(sw_gain_network),
  .sw_output_feedback(sw_output_feedback),
  .sw_noninv_cross_connect(sw_noninv_cross_connect),
  .sw_high_reference(sw_high_reference),
  .sw_mid_reference(sw_mid_reference),
  .sw_low_reference(sw_low_reference),
  .amp2_noninv_pin(amp2_noninv_pin), .amp2_inv_pin(amp2_inv_pin),
  .amp2_output_pin(amp2_output_pin), .amp2_cal_active(amp2_cal_active),
  .comp1_enable(comp1_enable),
  .comp1_noninv_from_pin(comp1_noninv_from_pin),
  .comp1_inv_from_pin(comp1_inv_from_pin),
  .comp1_offset_cal_mode(comp1_offset_cal_mode),
  .comp1_irq_trigger(comp1_irq_trigger));

// ==== tb/a2c1_comp_model.sv ====
// Behavioural comparator driving the block's asynchronous result input.
// Assumes the bench sets the wanted level; edges land between clocks.
`timescale 1ns/1ps
module a2c1_comp_model (
  // Bench command
  input  wire logic want,
  // Result toward the block
  output logic      comp1_result_async
);
  // Off-clock settling delay makes the synchroniser earn its keep
  initial comp1_result_async = 1'h0;
  always @(want) comp1_result_async <= #3 want;
endmodule : a2c1_comp_model

// ==== tb/a2c1_ctrl_tb_top.sv ====
// Self-checking bench for the amplifier-2 and comparator-1 control block.
// Assumes the comparator model on the result input, APB at 100 MHz.
`timescale 1ns/1ps
module a2c1_ctrl_tb_top;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, res, irq;
  logic        want = 1'h0;
  logic        snap = 1'h0;
  logic [12:0] swv, e;
  logic [4:0]  av;
  logic [10:0] cv;
  logic [7:0]  irq_cnt = 8'h00;
  logic [7:0]  n;
  logic [31:0] r, seed;
  logic [32:0] rdq[$];
  logic [12:0] swq[$];
  int          checked = 0;
  int          miscompares = 0;
  int          cycles = 0;
  // Amp ctrl, amp route, expected {switches, pins, bypass}
  localparam logic [28:0] SWT [19] = '{
    {8'h7E, 8'h07, 13'h0000},
    {8'h01, 8'h00, 13'h0002},
    {8'h07, 8'h00, 13'h180E},
    {8'h05, 8'h00, 13'h0806},
    {8'h0D, 8'h00, 13'h0846},
    {8'h15, 8'h00, 13'h0826},
    {8'h1D, 8'h00, 13'h0816},
    {8'h1F, 8'h00, 13'h180E},
    {8'h03, 8'h04, 13'h140E},
    {8'h07, 8'h04, 13'h1C0F},
    {8'h01, 8'h04, 13'h0406},
    {8'hC7, 8'h00, 13'h180E},
    {8'h79, 8'h00, 13'h1802},
    {8'h23, 8'h00, 13'h110A},
    {8'h29, 8'h00, 13'h0042},
    {8'h31, 8'h00, 13'h0022},
    {8'h39, 8'h00, 13'h0012},
    {8'h05, 8'h01, 13'h0886},
    {8'h03, 8'h02, 13'h120A}};
  // Edge select, comparator reg 1, new level, expected pulses
  localparam logic [12:0] IRQT [9] = '{
    {2'h1, 8'h0D, 1'h1, 2'h1}, {2'h1, 8'h0D, 1'h0, 2'h0},
    {2'h2, 8'h0D, 1'h1, 2'h0}, {2'h2, 8'h0D, 1'h0, 2'h1},
    {2'h3, 8'h0D, 1'h1, 2'h1}, {2'h3, 8'h0D, 1'h0, 2'h1},
    {2'h3, 8'h05, 1'h1, 2'h0}, {2'h3, 8'h0C, 1'h0, 2'h0},
    {2'h0, 8'h0D, 1'h1, 2'h0}};
  localparam logic [7:0] RSTV [6] = '{8'h10, 8'h82, 8'h06, 8'h00, 8'h00,
                                      8'h00};

  a2c1_ctrl a2c1_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sw_noninv_pin(swv[12]),
    .sw_inv_pin(swv[11]), .sw_gain_network(swv[10]),
    .sw_inv_cross_connect(swv[9]), .sw_output_feedback(swv[8]),
    .sw_noninv_cross_connect(swv[7]), .sw_high_reference(swv[6]),
    .sw_mid_reference(swv[5]), .sw_low_reference(swv[4]),
    .amp2_noninv_pin(swv[3]), .amp2_inv_pin(swv[2]),
    .amp2_output_pin(swv[1]), .gain_input_resistor_bypass(swv[0]),
    .amp2_cal_active(av[4]), .amp2_cal_ref_noninv(av[3]),
    .amp2_gain_select(av[2:0]), .comp1_result_async(res),
    .comp1_enable(cv[10]), .comp1_pin_output_enable(cv[9]),
    .comp1_noninv_from_pin(cv[8]), .comp1_inv_from_pin(cv[7]),
    .comp1_offset_cal_mode(cv[6]), .comp1_cal_ref_select(cv[5]),
    .comp1_offset_trim(cv[4:0]), .comp1_irq_trigger(irq));
  a2c1_comp_model a2c1_comp_model_inst (.want(want),
                                        .comp1_result_async(res));

  initial forever #5 pclk = ~pclk;

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic test_done;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // Reads note {error, data}; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] d, input logic err);
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {24'h0, d};
    if (!wr)
      rdq.push_back({err, 24'h0, d});
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'h1 && !pwrite && rdq.size() > 0)
      check({pslverr, prdata}, rdq.pop_front());
    if (snap && swq.size() > 0) begin
      e = swq.pop_front();
      check({20'h0, swv}, {20'h0, e});
    end
    if (irq === 1'h1)
      irq_cnt <= irq_cnt + 8'h01;
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end

  initial begin
    seed = 32'h90FCDFD2;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 6; i++)
      apb(1'h0, 8'(i * 4), RSTV[i], 1'h0);
    apb(1'h0, 8'h18, 8'h00, 1'h1);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      apb(1'h1, 8'h00, r[7:0], 1'h0);
      apb(1'h0, 8'h00, {1'h0, r[6:0]}, 1'h0);
    end
    apb(1'h1, 8'h04, 8'hFF, 1'h0);
    apb(1'h0, 8'h04, 8'h8F, 1'h0);
    // cancellation forces selects, stored values return after
    apb(1'h1, 8'h04, 8'h0D, 1'h0);
    apb(1'h1, 8'h00, 8'h40, 1'h0);
    apb(1'h0, 8'h04, 8'h8F, 1'h0);
    check({22'h0, cv}, {22'h0, 11'h7C0});
    apb(1'h1, 8'h00, 8'h10, 1'h0);
    apb(1'h0, 8'h04, 8'h0D, 1'h0);
    check({22'h0, cv}, {22'h0, 11'h610});
    $display("register test done");
    foreach (SWT[i]) begin
      r = $random(seed);
      apb(1'h1, 8'h0C, {SWT[i][20:19], r[2:0], SWT[i][15:13]}, 1'h0);
      apb(1'h1, 8'h08, SWT[i][28:21], 1'h0);
      repeat (2) @(posedge pclk);
      swq.push_back(SWT[i][12:0]);
      snap <= 1'h1;
      @(posedge pclk);
      snap <= 1'h0;
      check({28'h0, av}, {28'h0, SWT[i][21] & SWT[i][27], SWT[i][28],
                          r[2:0]});
    end
    $display("switch test done");
    foreach (IRQT[i]) begin
      apb(1'h1, 8'h14, {6'h0, IRQT[i][12:11]}, 1'h0);
      apb(1'h1, 8'h04, IRQT[i][10:3], 1'h0);
      n = irq_cnt;
      want <= IRQT[i][2];
      repeat (10) @(posedge pclk);
      check({25'h0, irq_cnt - n}, {31'h0, IRQT[i][1:0]});
      apb(1'h0, 8'h00, {IRQT[i][2], 7'h10}, 1'h0);
    end
    $display("trigger test done");
    test_done();
  end
endmodule : a2c1_ctrl_tb_top
